// ===== rtl/rlk_access_port.sv
// Purpose: indirect processor access to the rtc lookup ram
// Assumes: registers reached by a plain strobe port, read data one cycle later
// Notes:   an access takes one cycle in ST_ACC after the strobe is seen
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module rlk_access_port
    import rlk_pkg::*;
(
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [DATA_W-1:0] REG_RDATA
);

    function automatic rlk_sel_type decode(input logic [ADDR_W-1:0] a);
        if (a == OFS_LKP_ADDR) begin
            decode = SEL_ADDR;
        end else if (a == OFS_LKP_DATA) begin
            decode = SEL_DATA;
        end else if (a == OFS_LKP_STRB) begin
            decode = SEL_STRB;
        end else begin
            decode = SEL_NONE;
        end
    endfunction : decode

    rlk_state_type     state_q;
    rlk_state_type     state_d;
    logic [LKA_W-1:0]  lka_q;
    logic [LKA_W-1:0]  lka_d;
    logic              auto_q;
    logic              auto_d;
    logic [7:0]        dat_q;
    logic [7:0]        dat_d;
    logic [1:0]        strb_q;
    logic [1:0]        strb_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic [7:0]        ram [RAM_DEPTH];
    logic              ram_we;
    rlk_sel_type       wsel;
    rlk_sel_type       rsel;

    assign wsel      = REG_WR ? decode(REG_ADDR) : SEL_NONE;
    assign rsel      = REG_RD ? decode(REG_ADDR) : SEL_NONE;
    // read has priority if software breaks the one-strobe rule
    assign ram_we    = (state_q == ST_ACC) && strb_q[BIT_WR_STRB] && !strb_q[BIT_RD_STRB];
    assign REG_RDATA = rdata_q;

    // access sequencer and strobe bits
    always_comb begin
        state_d = state_q;
        strb_d  = strb_q;
        case (state_q)
            ST_IDLE: begin
                if (strb_q != 2'h0) begin
                    state_d = ST_ACC;
                end
            end
            ST_ACC: begin
                state_d = ST_IDLE;
                strb_d  = 2'h0;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // setting wins over the completion clear; zeros never clear a busy strobe
        if (wsel == SEL_STRB) begin
            strb_d = strb_d | REG_WDATA[1:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
            strb_q  <= RST_LKP_STRB;
        end else begin
            state_q <= state_d;
            strb_q  <= strb_d;
        end
    end

    // address, auto flag and data byte
    always_comb begin
        lka_d  = lka_q;
        auto_d = auto_q;
        dat_d  = dat_q;
        if (wsel == SEL_ADDR) begin
            lka_d  = REG_WDATA[LKA_W-1:0];
            auto_d = REG_WDATA[BIT_AUTO_INC];
        end
        if (wsel == SEL_DATA) begin
            dat_d = REG_WDATA;
        end
        if (state_q == ST_ACC) begin
            if (strb_q[BIT_RD_STRB]) begin
                dat_d = ram[lka_q];
            end
            // completion step beats a same-cycle address write
            if (auto_q) begin
                lka_d = LKA_W'(lka_q + LKA_STEP);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            lka_q  <= RST_LKP_ADDR[LKA_W-1:0];
            auto_q <= RST_LKP_ADDR[BIT_AUTO_INC];
            dat_q  <= RST_LKP_DATA;
        end else begin
            lka_q  <= lka_d;
            auto_q <= auto_d;
            dat_q  <= dat_d;
        end
    end

    // read data stands one cycle after the read strobe, zero otherwise
    always_comb begin
        rdata_d = 8'h00;
        if (rsel == SEL_ADDR) begin
            rdata_d = {auto_q, lka_q};
        end else if (rsel == SEL_DATA) begin
            rdata_d = dat_q;
        end else if (rsel == SEL_STRB) begin
            rdata_d = {6'h00, strb_q};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // lookup ram itself has no reset, contents are software-loaded
    always_ff @(posedge REF_CLK) begin
        if (ram_we) begin
            ram[lka_q] <= dat_q;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    a_strobe_starts: assert property (
        (state_q == ST_IDLE && strb_q != 2'h0) |=> state_q == ST_ACC)
        else $error("strobe did not start an access");
    a_strobe_held: assert property (
        (state_q == ST_IDLE && strb_q[BIT_WR_STRB]) |=> strb_q[BIT_WR_STRB])
        else $error("write strobe dropped before completion");
    a_strobe_clears: assert property (
        (state_q == ST_ACC && !(REG_WR && REG_ADDR == OFS_LKP_STRB)) |=> strb_q == 2'h0)
        else $error("strobe not cleared at completion");
    a_auto_step: assert property (
        (state_q == ST_ACC && auto_q) |=> lka_q == $past(lka_q) + LKA_STEP)
        else $error("address did not advance");
    a_no_step: assert property (
        (state_q == ST_ACC && !auto_q && !(REG_WR && REG_ADDR == OFS_LKP_ADDR))
        |=> lka_q == $past(lka_q))
        else $error("address moved without auto-increment");
    a_read_fetch: assert property (
        (state_q == ST_ACC && strb_q[BIT_RD_STRB]) |=> dat_q == ram[$past(lka_q)])
        else $error("read data not loaded from lookup ram");
    a_write_store: assert property (
        ram_we |=> ram[$past(lka_q)] == $past(dat_q))
        else $error("lookup ram byte not written");
    a_rdata_idle: assert property (
        !$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    a_read_held: assert property (
        (state_q == ST_IDLE && strb_q[BIT_RD_STRB]) |=> strb_q[BIT_RD_STRB])
        else $error("read strobe dropped before completion");
    a_idle_quiet: assert property (
        (state_q == ST_IDLE && strb_q == 2'h0) |=> state_q == ST_IDLE)
        else $error("access started with no strobe set");
    a_acc_ends: assert property (
        state_q == ST_ACC |=> state_q == ST_IDLE)
        else $error("access did not complete");
    a_addr_load: assert property (
        (REG_WR && REG_ADDR == OFS_LKP_ADDR && state_q == ST_IDLE)
        |=> {auto_q, lka_q} == $past(REG_WDATA))
        else $error("address register write lost");
    a_data_load: assert property (
        (REG_WR && REG_ADDR == OFS_LKP_DATA && !(state_q == ST_ACC && strb_q[BIT_RD_STRB]))
        |=> dat_q == $past(REG_WDATA))
        else $error("data register write lost");

    // register readback, one cycle after the read strobe
    a_rdata_addr: assert property (
        (REG_RD && REG_ADDR == OFS_LKP_ADDR) |=> REG_RDATA == {$past(auto_q), $past(lka_q)})
        else $error("address readback wrong");
    a_rdata_strb: assert property (
        (REG_RD && REG_ADDR == OFS_LKP_STRB) |=> REG_RDATA == {6'h00, $past(strb_q)})
        else $error("strobe readback wrong");
    a_rdata_data: assert property (
        (REG_RD && REG_ADDR == OFS_LKP_DATA) |=> REG_RDATA == $past(dat_q))
        else $error("data readback wrong");

    c_read_op: cover property (state_q == ST_ACC && strb_q[BIT_RD_STRB]);
    c_write_auto: cover property (ram_we && auto_q);
    c_poll_busy: cover property (REG_RD && REG_ADDR == OFS_LKP_STRB && strb_q != 2'h0);
    c_addr_wrap: cover property (state_q == ST_ACC && auto_q && lka_q == 7'h7F);
    c_data_readback: cover property (REG_RD && REG_ADDR == OFS_LKP_DATA && dat_q != 8'h00);

endmodule : rlk_access_port

// ===== rtl/rlk_pkg.sv
// Purpose: constants for the rtc lookup ram access port
// Assumes: 16-bit register address, 8-bit register data
// Notes:   one register per byte address
package rlk_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam int          LKA_W          = 7;
    localparam int          RAM_DEPTH      = 128;
    localparam logic [15:0] OFS_LKP_ADDR   = 16'h2887;
    localparam logic [15:0] OFS_LKP_DATA   = 16'h2888;
    localparam logic [15:0] OFS_LKP_STRB   = 16'h2889;
    localparam int          BIT_AUTO_INC   = 7;
    localparam int          BIT_RD_STRB    = 1;
    localparam int          BIT_WR_STRB    = 0;
    localparam logic [7:0]  RST_LKP_ADDR   = 8'h00;
    localparam logic [7:0]  RST_LKP_DATA   = 8'h00;
    localparam logic [1:0]  RST_LKP_STRB   = 2'h0;
    localparam logic [6:0]  LKA_STEP       = 7'h01;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ACC  = 1'b1
    } rlk_state_type;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_ADDR = 2'b01,
        SEL_DATA = 2'b10,
        SEL_STRB = 2'b11
    } rlk_sel_type;
endpackage : rlk_pkg

// ===== verif/rlk_access_port_tb.sv
// Purpose: self-checking bench for the lookup ram access port
// Assumes: ram has no pins, so its model lives here
// Notes:   read data sampled 1 ns after the taking edge
`timescale 1ns/1ps
module rlk_access_port_tb;
    import rlk_pkg::*;
    logic              REF_CLK = 1'b0;
    logic              RST_B = 1'b0;
    logic [ADDR_W-1:0] REG_ADDR = '0;
    logic [DATA_W-1:0] REG_WDATA = '0;
    logic              REG_WR = 1'b0;
    logic              REG_RD = 1'b0;
    logic [DATA_W-1:0] REG_RDATA;
    int                n_mismatch = 0;
    int                n_tests = 0;
    int                cyc = 0;
    int                m_ram [RAM_DEPTH];
    int                m_adr = 0;
    int                m_auto = 0;
    int                m_dat = 0;
    logic [7:0]        v;
    rlk_access_port uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
    always #25 REF_CLK = ~REF_CLK;
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    // whole run needs well under 2000 cycles
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask : rd
    task automatic set_adr(input int au, input int a);
        m_auto = au;
        m_adr = a;
        wr(OFS_LKP_ADDR, 8'(au * 128 + a));
    endtask : set_adr
    task automatic set_dat();
        m_dat = $urandom % 256;
        wr(OFS_LKP_DATA, 8'(m_dat));
    endtask : set_dat
    // one strobe, polled until clear before the next one
    task automatic op(input int b);
        wr(OFS_LKP_STRB, 8'h01 << b);
        rd(OFS_LKP_STRB, v);
        chk("strobe busy", v, 8'h01 << b);
        // the next poll may still land inside the access
        for (int p = 0; p < 4 && v != 8'h00; p++)
            rd(OFS_LKP_STRB, v);
        chk("strobe done", v, 8'h00);
        if (b == BIT_WR_STRB)
            m_ram[m_adr] = m_dat;
        else
            m_dat = m_ram[m_adr];
        if (m_auto != 0)
            m_adr = (m_adr + 1) % RAM_DEPTH;
        rd(OFS_LKP_ADDR, v);
        chk("address", v, 8'(m_auto * 128 + m_adr));
        rd(OFS_LKP_DATA, v);
        chk("data", v, 8'(m_dat));
    endtask : op
    initial begin
        void'($urandom(32'h6B36));
        repeat (16) @(posedge REF_CLK);
        RST_B <= 1'b1;
        @(posedge REF_CLK);
        #1 wr(16'h2886, 8'hA5);
        rd(OFS_LKP_ADDR, v);
        chk("reset address", v, RST_LKP_ADDR);
        rd(OFS_LKP_DATA, v);
        chk("reset data", v, RST_LKP_DATA);
        rd(OFS_LKP_STRB, v);
        chk("reset strobes", v, {6'h00, RST_LKP_STRB});
        rd(16'h288A, v);
        chk("unmapped", v, 8'h00);
        // start at 126 so the auto step wraps past 127
        for (int k = 0; k < 2; k++) begin
            set_adr(1, 126);
            for (int j = 0; j < 3; j++) begin
                if (k == 0)
                    set_dat();
                op(k == 0 ? BIT_WR_STRB : BIT_RD_STRB);
            end
        end
        repeat (4) begin
            set_adr(0, $urandom % RAM_DEPTH);
            set_dat();
            op(BIT_WR_STRB);
            set_dat();
            op(BIT_RD_STRB);
        end
        summarize();
    end
endmodule : rlk_access_port_tb
